// >>> design/ebd_slave.v
// Expansion bus plug-in card slave: data phase, burst and quick interrupt
// How it works
// - Card latches multiplexed address when full-cycle strobe falls.
// - Data buffers stay disabled until master raises data output enable.
// - Under data output enable, slave drives reads, master drives writes.
// - Read data valid at acknowledge; write data valid at a byte strobe.
// - Lane 3 covers bits 31..24, lane 0 bits 7..0.
// - Cachable read returns all four bytes regardless of strobes.
// - Writes change only strobed bytes of the addressed word.
// - Slave always drives acknowledge: reads after data, writes after capture.
// - Write data goes to a holding buffer so acknowledge comes early.
// - Cache inhibit is driven together with the slot slave response.
// - Non-cachable card inhibits caching and honours strobes on reads.
// - Burst acknowledge is asserted together with slot slave response.
// - Each new burst request carries new short address and write data.
// - Poll phase lasts 30 to 100 ns; vector acknowledge within 100 ns.
// - Responding card asserts slot slave response quickly after strobe.
`timescale 1ns/100ps
`default_nettype none
`include "ebd_consts.vh"
module ebd_slave #(
  parameter [23:0] BASE_ADDR = 24'h40_0000,
  parameter [23:0] ADDR_MASK = 24'hFF_FF00,
  parameter CACHABLE = 1'b1,
  parameter BURST_OK = 1'b1,
  parameter QINT_OK = 1'b1,
  parameter [7:0] QINT_VECTOR = 8'h40
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Bus strobes and direction, active low where named _n
  input wire full_cycle_strobe_n_in,
  input wire data_output_enable_in,
  input wire [3:0] byte_lane_strobe_n_in,
  input wire burst_transfer_request_n_in,
  input wire read_in,
  // Addresses
  input wire [23:0] mux_addr_in,
  input wire [5:0] short_addr_in,
  input wire [2:0] space_in,
  // Data bus, three signals
  input wire [31:0] data_in,
  output reg [31:0] data_out,
  output wire data_oe_out,
  // Slave responses, active low
  output wire slot_slave_response_n_out,
  output wire transfer_acknowledge_n_out,
  output wire cache_inhibit_n_out,
  output wire burst_transfer_acknowledge_n_out,
  // Local interrupt request for the quick interrupt cycle
  input wire qint_pending_in,
  // Status
  output wire fifo_busy_out
);
  localparam [2:0] SPACE_CPU = 3'h7;
  // Synchronisers
  reg [1:0] fcs_sync_reg;
  reg [1:0] doe_sync_reg;
  reg [1:0] burst_transfer_request_sync_reg;
  reg [3:0] ds_sync1_reg;
  reg [3:0] ds_sync2_reg;
  reg burst_transfer_request_prev_reg;
  // State
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] space_latch_reg;
  reg selected_reg;
  reg burst_reg;
  reg ack_reg;
  reg drive_reg;
  reg [3:0] qcnt_reg;
  // Storage
  reg [31:0] mem_reg [0:`EBD_MEM_WORDS-1];
  reg [3:0] wr_lat_reg;
  wire fcs_act;
  wire doe_act;
  wire burst_transfer_request_act;
  wire burst_transfer_request_rise;
  wire ds_any;
  wire hit;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`EBD_FIFO_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire [31:0] rd_word;
  wire [31:0] wr_word;
  wire [31:0] lane_mask;
  wire [31:0] merge_word;
  reg fifo_push;

  always @(posedge clk_in) begin
    if (rst_in) begin
      fcs_sync_reg <= 2'h3;
      doe_sync_reg <= 2'h0;
      burst_transfer_request_sync_reg <= 2'h3;
      ds_sync1_reg <= 4'hF;
      ds_sync2_reg <= 4'hF;
      burst_transfer_request_prev_reg <= 1'b0;
    end else begin
      fcs_sync_reg <= {fcs_sync_reg[0], full_cycle_strobe_n_in};
      doe_sync_reg <= {doe_sync_reg[0], data_output_enable_in};
      burst_transfer_request_sync_reg <= {burst_transfer_request_sync_reg[0], burst_transfer_request_n_in};
      ds_sync1_reg <= byte_lane_strobe_n_in;
      ds_sync2_reg <= ds_sync1_reg;
      burst_transfer_request_prev_reg <= burst_transfer_request_act;
    end
  end

  assign fcs_act = ~fcs_sync_reg[1];
  assign doe_act = doe_sync_reg[1];
  assign burst_transfer_request_act = ~burst_transfer_request_sync_reg[1];
  assign burst_transfer_request_rise = burst_transfer_request_act && !burst_transfer_request_prev_reg;
  // any strobe marks write data valid
  assign ds_any = ~(&ds_sync2_reg);
  // Only the four memory spaces hit here, CPU space 7 answers via the quick interrupt path; reserved codes 0, 3 and 4 stay silent
  assign hit = ((mux_addr_in & ADDR_MASK) == (BASE_ADDR & ADDR_MASK)) &&
               ((space_in == 3'h1) || (space_in == 3'h2) ||
                (space_in == 3'h5) || (space_in == 3'h6));

  // per-lane byte mask, lane n covers bits 8n+7..8n
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lanes
      assign lane_mask[8*g+7:8*g] = {8{~ds_sync2_reg[g]}};
    end
  endgenerate

  // Next state
  always @* begin
    state_next = state_reg;
    fifo_push = 1'b0;
    case (state_reg)
      `EBD_ST_IDLE: begin
        if (fcs_act) begin
          state_next = `EBD_ST_DECODE;
        end
      end
      `EBD_ST_DECODE: begin
        if (!selected_reg) begin
          state_next = `EBD_ST_WAITDOE;
        end else if (space_latch_reg == SPACE_CPU) begin
          state_next = `EBD_ST_QINT;
        end else begin
          state_next = `EBD_ST_WAITDOE;
        end
      end
      `EBD_ST_WAITDOE: begin
        if (selected_reg && doe_act) begin
          state_next = read_in ? `EBD_ST_READ : `EBD_ST_WRITE;
        end
      end
      `EBD_ST_READ: begin
        state_next = `EBD_ST_ACK;
      end
      `EBD_ST_WRITE: begin
        // hold in FIFO, stall when full
        if (ds_any && fifo_in_ready) begin
          fifo_push = 1'b1;
          state_next = `EBD_ST_ACK;
        end
      end
      `EBD_ST_ACK: begin
        // burst gap when request drops; the next beat starts on its rise
        if (burst_reg && !burst_transfer_request_act) begin
          state_next = `EBD_ST_BURSTGAP;
        end
      end
      `EBD_ST_BURSTGAP: begin
        if (burst_transfer_request_rise) begin
          state_next = read_in ? `EBD_ST_READ : `EBD_ST_WRITE;
        end
      end
      `EBD_ST_QINT: begin
        if (qcnt_reg >= `EBD_POLL_MIN_CYC) begin
          state_next = `EBD_ST_ACK;
        end
      end
      default: begin
        state_next = `EBD_ST_IDLE;
      end
    endcase
    if (!fcs_act) begin
      state_next = `EBD_ST_IDLE;
      fifo_push = 1'b0;
    end
  end

  // Cycle control registers
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= `EBD_ST_IDLE;
      space_latch_reg <= 3'h0;
      selected_reg <= 1'b0;
      burst_reg <= 1'b0;
      ack_reg <= 1'b0;
      drive_reg <= 1'b0;
      qcnt_reg <= 4'h0;
      data_out <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == `EBD_ST_IDLE && fcs_act) begin
        space_latch_reg <= space_in;
        selected_reg <= hit || (QINT_OK && space_in == SPACE_CPU && qint_pending_in);
      end
      // handshake done once request seen in data time
      if (state_next == `EBD_ST_IDLE) begin
        burst_reg <= 1'b0;
      end else if (BURST_OK && burst_transfer_request_act && selected_reg &&
                   (state_reg == `EBD_ST_WAITDOE || state_reg == `EBD_ST_READ ||
                    state_reg == `EBD_ST_WRITE)) begin
        burst_reg <= 1'b1;
      end
      ack_reg <= (state_next == `EBD_ST_ACK);
      // drive only on selected reads under enable
      drive_reg <= selected_reg && read_in && doe_act && (state_next != `EBD_ST_IDLE);
      if (state_reg == `EBD_ST_QINT) begin
        qcnt_reg <= qcnt_reg + 4'h1;
      end else begin
        qcnt_reg <= 4'h0;
      end
      if (state_reg == `EBD_ST_READ) begin
        // cachable: all bytes; else honour strobes
        data_out <= CACHABLE ? rd_word : (rd_word & lane_mask);
      end else if (state_reg == `EBD_ST_QINT) begin
        data_out <= {24'h00_0000, QINT_VECTOR};
      end
    end
  end

  // Reads bypass the FIFO, so a read chasing a write to one word can see it stale
  assign rd_word = mem_reg[short_addr_in];

  // Write holding FIFO: address, mask bits and data
  ebd_fifo #(
    .WIDTH(`EBD_FIFO_W),
    .DEPTH(`EBD_FIFO_D),
    .AW(`EBD_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({short_addr_in, ~ds_sync2_reg, data_in}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(wr_lat_reg == `EBD_WR_LAT),
    .out_data_out(fifo_out_data)
  );

  // Slow memory: one write per few cycles, so the FIFO really fills in bursts
  assign fifo_pop = fifo_out_valid && (wr_lat_reg == `EBD_WR_LAT);
  assign wr_word = mem_reg[fifo_out_data[41:36]];
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_lat_reg <= 4'h0;
    end else if (fifo_pop) begin
      wr_lat_reg <= 4'h0;
    end else if (fifo_out_valid) begin
      wr_lat_reg <= wr_lat_reg + 4'h1;
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : wlanes
      assign merge_word[8*g+7:8*g] = fifo_out_data[32+g] ?
        fifo_out_data[8*g+7:8*g] : wr_word[8*g+7:8*g];
    end
  endgenerate

  // One writer process keeps the memory free of competing drivers
  always @(posedge clk_in) begin
    if (fifo_pop) begin
      mem_reg[fifo_out_data[41:36]] <= merge_word;
    end
  end

  // Outputs; cache inhibit rides with slave response
  assign slot_slave_response_n_out = ~(selected_reg && state_reg != `EBD_ST_IDLE);
  assign cache_inhibit_n_out = ~(selected_reg && state_reg != `EBD_ST_IDLE && !CACHABLE);
  // burst ack falls with slave response
  assign burst_transfer_acknowledge_n_out = ~(BURST_OK && selected_reg &&
                                              state_reg != `EBD_ST_IDLE);
  assign transfer_acknowledge_n_out = ~ack_reg;
  assign data_oe_out = drive_reg;
  assign fifo_busy_out = fifo_out_valid;
endmodule
`default_nettype wire

// >>> design/ebd_consts.vh
// Constants for the expansion bus data-phase slave
`ifndef EBD_CONSTS_VH
`define EBD_CONSTS_VH
`define EBD_CLK_NS 10
`define EBD_POLL_MIN_NS 30
`define EBD_POLL_MAX_NS 100
`define EBD_VEC_MAX_NS 100
`define EBD_MEM_WORDS 64
`define EBD_ADDR_W 6
`define EBD_FIFO_W 42
`define EBD_FIFO_D 16
`define EBD_FIFO_AW 4
// Write pipeline delay in cycles for the internal memory write
`define EBD_WR_LAT 4'h3
// Poll phase bounds in cycles, least rounds up, longest rounds down
`define EBD_POLL_MIN_CYC ((`EBD_POLL_MIN_NS + `EBD_CLK_NS - 1) / `EBD_CLK_NS)
`define EBD_POLL_MAX_CYC (`EBD_POLL_MAX_NS / `EBD_CLK_NS)
`define EBD_VEC_MAX_CYC (`EBD_VEC_MAX_NS / `EBD_CLK_NS)
// States
`define EBD_ST_IDLE 3'h0
`define EBD_ST_DECODE 3'h1
`define EBD_ST_WAITDOE 3'h2
`define EBD_ST_READ 3'h3
`define EBD_ST_WRITE 3'h4
`define EBD_ST_ACK 3'h5
`define EBD_ST_BURSTGAP 3'h6
`define EBD_ST_QINT 3'h7
`endif

// >>> design/ebd_fifo.v
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ebd_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and count update
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Storage, no reset needed on data
  always @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// >>> sim/ebd_slave_sva.sv
// Port-level checks for the expansion bus slave
`timescale 1ns/100ps
`default_nettype none
module ebd_slave_sva #(
  parameter [23:0] BASE_ADDR = 24'h40_0000,
  parameter [23:0] ADDR_MASK = 24'hff_ff00,
  parameter CACHABLE = 1'b1
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Master side
  input wire full_cycle_strobe_n_in,
  input wire data_output_enable_in,
  input wire read_in,
  input wire [23:0] mux_addr_in,
  input wire [2:0] space_in,
  // Card responses
  input wire data_oe_out,
  input wire slot_slave_response_n_out,
  input wire transfer_acknowledge_n_out,
  input wire cache_inhibit_n_out,
  input wire burst_transfer_acknowledge_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Decode as it stands at the strobe edge, before the address leaves
  wire hit = ((mux_addr_in & ADDR_MASK) == (BASE_ADDR & ADDR_MASK)) &&
    (space_in inside {3'h1, 3'h2, 3'h5, 3'h6});
  sequence s_start;
    $fell(full_cycle_strobe_n_in);
  endsequence
  // Two synchroniser edges pass before any answer
  sequence s_sync_gap;
    slot_slave_response_n_out [*2];
  endsequence
  AST_RESP_TIME: assert property (s_start ##0 hit |->
    s_sync_gap ##[1:3] !slot_slave_response_n_out) else $error("late or early response");
  AST_NO_HIT: assert property (s_start ##0 (!hit && space_in != 3'h7) |->
    slot_slave_response_n_out [*8]) else $error("response on a miss");
  AST_ADDR_HELD: assert property ($fell(slot_slave_response_n_out) |->
    !slot_slave_response_n_out [*4]) else $error("response lost with address");
  AST_OE_GATE: assert property (!data_output_enable_in [*5] |->
    !data_oe_out) else $error("data driven without enable");
  AST_OE_READ: assert property (data_oe_out |-> read_in)
    else $error("data driven on a write");
  AST_RD_ACK: assert property ($fell(transfer_acknowledge_n_out) && read_in |->
    data_oe_out) else $error("read ack without data");
  AST_ACK_DUE: assert property ($rose(data_output_enable_in) ##1
    !slot_slave_response_n_out |-> ##[1:8] !transfer_acknowledge_n_out)
    else $error("ack missing");
  AST_CACHE_INHIBIT: assert property (cache_inhibit_n_out ==
    (slot_slave_response_n_out | CACHABLE)) else $error("cache inhibit wrong");
  AST_BURST_TRANSFER_ACKNOWLEDGE: assert property ($fell(slot_slave_response_n_out) |->
    $fell(burst_transfer_acknowledge_n_out)) else $error("burst ack not with response");
  AST_IDLE: assert property (full_cycle_strobe_n_in [*6] |->
    slot_slave_response_n_out && transfer_acknowledge_n_out &&
    burst_transfer_acknowledge_n_out && !data_oe_out) else $error("outputs not released");
endmodule
bind ebd_slave ebd_slave_sva #(.BASE_ADDR(BASE_ADDR), .ADDR_MASK(ADDR_MASK),
  .CACHABLE(CACHABLE)) ebd_slave_sva_i (.clk_in, .rst_in, .full_cycle_strobe_n_in,
  .data_output_enable_in, .read_in, .mux_addr_in, .space_in, .data_oe_out,
  .slot_slave_response_n_out, .transfer_acknowledge_n_out, .cache_inhibit_n_out,
  .burst_transfer_acknowledge_n_out);
`default_nettype wire

// >>> sim/ebd_bus_master.sv
// Behavioural bus master facing the slave card
`timescale 1ns/100ps
`default_nettype none
module ebd_bus_master (
  // Clock
  input wire logic clk_in,
  // Master-driven lines
  output logic fcs_n_out,
  output logic doe_out,
  output logic [3:0] ds_n_out,
  output logic burst_transfer_request_n_out,
  output logic read_out,
  output logic [23:0] addr_out,
  output logic [5:0] short_out,
  output logic [2:0] space_out,
  output logic [31:0] wire_out,
  // Card data and acknowledge
  input wire logic [31:0] card_data_in,
  input wire logic card_oe_in,
  input wire logic ack_n_in,
  // One-cycle report per beat
  output logic done_out,
  output logic got_out,
  output logic [31:0] rdata_out
);
  logic [31:0] wdata_reg;
  logic [31:0] last_reg;
  // wire owner; an idle bus keeps changing so stale data never matches
  assign wire_out = card_oe_in ? card_data_in :
    (doe_out && !read_out) ? wdata_reg : ~last_reg;
  always @(posedge clk_in) last_reg <= wire_out;
  initial begin
    {fcs_n_out, burst_transfer_request_n_out, ds_n_out} = 6'h3f;
    {doe_out, read_out, done_out, got_out} = 4'h0;
    {addr_out, short_out, space_out} = 33'h0;
    {wdata_reg, last_reg, rdata_out} = 96'h0;
  end
  // strobe after address, then enable, then lanes
  task automatic xfer(input logic rd, input logic [23:0] a, input logic [2:0] sp,
    input logic [5:0] sa, input logic [3:0] ln, input logic [31:0] wd, input int n);
    int k;
    begin
      @(negedge clk_in);
      read_out = rd;
      addr_out = a;
      space_out = sp;
      short_out = sa;
      wdata_reg = wd;
      @(negedge clk_in);
      // slot grant is not modelled: this card only ever answers
      fcs_n_out = 1'b0;
      repeat (2) @(negedge clk_in);
      doe_out = 1'b1;
      @(negedge clk_in);
      // Multiplexed address goes away after the strobe
      addr_out = ~a;
      for (int i = 0; i < n; i++) begin
        // contiguous lanes, request at data time
        ds_n_out = ~ln;
        burst_transfer_request_n_out = (n == 1);
        k = 0;
        @(posedge clk_in);
        while (ack_n_in !== 1'b0 && k < 30) begin
          k++;
          @(posedge clk_in);
        end
        got_out = (ack_n_in === 1'b0);
        rdata_out = wire_out;
        @(negedge clk_in);
        done_out = 1'b1;
        ds_n_out = 4'hf;
        burst_transfer_request_n_out = 1'b1;
        @(negedge clk_in);
        done_out = 1'b0;
        // off gap, then new short address and data
        if (i + 1 < n) begin
          k = 0;
          while (ack_n_in !== 1'b1 && k < 30) begin
            k++;
            @(negedge clk_in);
          end
          @(negedge clk_in);
          short_out = sa + 6'(i + 1);
          wdata_reg = wd + 32'(i + 1);
          @(negedge clk_in);
        end
      end
      fcs_n_out = 1'b1;
      doe_out = 1'b0;
      repeat (6) @(negedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the expansion bus slave
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [23:0] BASE = 24'h40_0000;
  // Quick interrupt vector chosen by the bench, value is arbitrary
  localparam logic [7:0] QVEC = 8'h5a;
  logic clk_in;
  logic rst_in;
  logic qint_pending_in;
  logic [31:0] seed_reg;
  logic [31:0] mem [64];
  logic [33:0] expq [$];
  logic [33:0] exp_now;
  logic [3:0] pat [10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf};
  logic [2:0] sps [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  int bad_count;
  int comparisons;
  int cycles;
  wire logic fcs_n, data_output_enable, burst_transfer_request_n, rd, slv_n, ack_n, cache_inhibit_n, burst_transfer_acknowledge_n, oe, done, got, busy;
  wire logic [3:0] ds_n;
  wire logic [23:0] ma;
  wire logic [5:0] sa;
  wire logic [2:0] sp;
  wire logic [31:0] dw, dc, rdat;
  ebd_slave #(.QINT_VECTOR(QVEC)) ebd_slave_i (.clk_in(clk_in), .rst_in(rst_in),
    .full_cycle_strobe_n_in(fcs_n),
    .data_output_enable_in(data_output_enable), .byte_lane_strobe_n_in(ds_n),
    .burst_transfer_request_n_in(burst_transfer_request_n), .read_in(rd), .mux_addr_in(ma),
    .short_addr_in(sa), .space_in(sp), .data_in(dw), .data_out(dc), .data_oe_out(oe),
    .slot_slave_response_n_out(slv_n), .transfer_acknowledge_n_out(ack_n),
    .cache_inhibit_n_out(cache_inhibit_n), .burst_transfer_acknowledge_n_out(burst_transfer_acknowledge_n),
    .qint_pending_in(qint_pending_in), .fifo_busy_out(busy));
  ebd_bus_master ebd_bus_master_i (.clk_in(clk_in), .fcs_n_out(fcs_n), .doe_out(data_output_enable),
    .ds_n_out(ds_n), .burst_transfer_request_n_out(burst_transfer_request_n), .read_out(rd), .addr_out(ma), .short_out(sa),
    .space_out(sp), .wire_out(dw), .card_data_in(dc), .card_oe_in(oe), .ack_n_in(ack_n),
    .done_out(done), .got_out(got), .rdata_out(rdat));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_ack(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Notes the outcome of every beat, then hands the cycle to the master
  task automatic op(input logic r, input logic [23:0] a, input logic [2:0] s,
    input logic [5:0] w, input logic [3:0] ln, input int n);
    logic hit;
    logic [31:0] d;
    logic [5:0] x;
    begin
      hit = ((a[23:8] == BASE[23:8]) && (s inside {3'h1, 3'h2, 3'h5, 3'h6})) ||
        (s == 3'h7 && qint_pending_in);
      for (int i = 0; i < n; i++) begin
        x = w + 6'(i);
        d = seed_reg + 32'(i);
        for (int b = 0; b < 4; b++)
          if (!r && hit && ln[b]) mem[x][8*b+:8] = d[8*b+:8];
        expq.push_back({r & hit, hit, (s == 3'h7) ? {24'h00_0000, QVEC} : mem[x]});
      end
      ebd_bus_master_i.xfer(r, a, s, w, ln, seed_reg, n);
      seed_reg = nxt(seed_reg);
    end
  endtask
  // Each reported beat retires the oldest note
  always @(posedge clk_in) begin
    if (done === 1'b1) begin
      exp_now = expq.pop_front();
      cmp_ack(got, exp_now[32]);
      if (exp_now[33])
        cmp_data(rdat, exp_now[31:0]);
    end
  end
  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    rst_in = 1'b1;
    qint_pending_in = 1'b0;
    seed_reg = 32'h0000_47ad;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    // Whole word, a contiguous partial write, then a one-lane read
    foreach (pat[i]) begin
      op(1'b0, BASE, sps[i % 4], 6'(i), 4'hf, 1);
      op(1'b0, BASE, sps[i % 4], 6'(i), pat[i], 1);
      op(1'b1, BASE, sps[i % 4], 6'(i), 4'h1, 1);
    end
    // Foreign address and reserved space get no answer and change nothing
    op(1'b0, BASE ^ 24'h01_0000, 3'h1, 6'h0, 4'hf, 1);
    op(1'b0, BASE, 3'h0, 6'h0, 4'hf, 1);
    op(1'b0, BASE, 3'h3, 6'h0, 4'hf, 1);
    // Quick interrupt answers with the vector only while one is pending
    qint_pending_in = 1'b1;
    op(1'b1, BASE, 3'h7, 6'h0, 4'hf, 1);
    qint_pending_in = 1'b0;
    op(1'b1, BASE, 3'h7, 6'h0, 4'hf, 1);
    op(1'b1, BASE, 3'h1, 6'h0, 4'hf, 1);
    // Three-beat bursts each way
    op(1'b0, BASE, 3'h1, 6'h20, 4'hf, 3);
    op(1'b1, BASE, 3'h2, 6'h20, 4'hf, 3);
    repeat (20) @(negedge clk_in);
    cmp_ack(busy, 1'b0);
    cmp_ack(expq.size() == 0, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
